// ===== src/mib_bank.sv
// module information register bank: pointer and load options per module
// Summary of operation
// - select lsb: 0 pointer, 1 load options
// - access only in shutdown; else read zero
// - row n describes reconfigurable module n
// - pointer bits 15:0 give load image row
// - pointer bits 31:16 give clearing image row
// - options bits 31:13 read zero, writes dropped
// - duration field is reset length minus one
// - reset code: none, reserved, low, high
// - bit 2 requests software start-up
// - shutdown code: none, hw, hw-sw, sw-hw
`timescale 1ns/1ps
module mib_bank
  import mib_pkg::*;
#(
  parameter int NUM_RM     = 4,     // reconfigurable modules in this socket
  parameter int ROW_W      = 2,     // bits for the row part of register select
  parameter bit HAS_CLEAR  = 1'h0   // family needs a clearing image
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // register interface
  input  wire logic [ROW_W:0]        reg_sel,
  input  wire logic                  reg_wr,
  input  wire logic [31:0]           reg_wdata,
  output logic      [31:0]           reg_rdata,
  // socket manager state
  input  wire logic                  in_shutdown,
  // load request from the sequencer
  input  wire logic                  load_start,
  input  wire logic [ROW_W-1:0]      load_rm_id,
  // selected module's decoded information
  output logic      [LOAD_ROW_W-1:0] load_image_row,
  output logic      [CLEAR_ROW_W-1:0] clearing_image_row,
  output logic                       startup_needed,
  output logic      [1:0]            shutdown_mode,
  output logic      [1:0]            reset_mode,
  // module reset
  output logic                       rm_reset,
  output logic                       rm_reset_busy
);

  // layout of one row, as seen through reg_sel
  //   lsb 0, pointer:      15:0 load image row
  //                        31:16 clearing image row, or zero
  //   lsb 1, load options: 31:13 always zero
  //                        12:5 reset length minus one
  //                        4:3 reset code
  //                        2 software start-up flag
  //                        1:0 shutdown code
  // every field clears to zero on rst
  // both registers of a row are reachable only while in_shutdown is high

  // small decoders for the register side; row_exists also serves the load side

  // true when a row index names an implemented row; the select field can
  // reach more rows than exist when NUM_RM is not a power of two
  function automatic logic row_exists(input logic [ROW_W-1:0] r);
    row_exists = int'(r) < NUM_RM;
  endfunction

  // pointer value as stored: upper half reserved on some families;
  // dropping it at write time keeps reads and the load side in step
  function automatic logic [31:0] mask_ptr(input logic [31:0] v);
    mask_ptr = HAS_CLEAR ? v : {16'h0000, v[LOAD_ROW_W-1:0]};
  endfunction

  // options word as read back: reserved upper bits always zero
  function automatic logic [31:0] opt_word(input logic [OPT_USED_W-1:0] v);
    opt_word = 32'(v);
  endfunction

  // per-row storage; options keep only the used bits, so the reserved
  // bits cost no flops and can never read back as anything but zero
  logic [31:0]           ptr_q [NUM_RM];    // pointer rows, registered
  logic [31:0]           ptr_d [NUM_RM];    // pointer rows, next value
  logic [OPT_USED_W-1:0] opt_q [NUM_RM];    // options rows, registered
  logic [OPT_USED_W-1:0] opt_d [NUM_RM];    // options rows, next value
  logic [31:0]           rdata_q, rdata_d;  // registered read data

  // row and register from the select lines
  logic [ROW_W-1:0]  row;       // row part of the select
  logic              reg_pick;  // register within the row
  logic              row_ok;    // row is implemented
  logic              acc_ok;    // access allowed in this cycle
  logic [NUM_RM-1:0] row_wr;    // per-row write strobe

  assign row      = reg_sel[ROW_W:1];
  assign reg_pick = reg_sel[SEL_LSB_POS];
  assign row_ok   = row_exists(row);
  // the socket manager must be shut down for any access at all
  assign acc_ok   = in_shutdown && row_ok;

  // write decode, one generate slice per row
  // a write to a missing row or outside shutdown changes nothing;
  // back to back writes need no gap between them
  genvar g;
  generate
    for (g = 0; g < NUM_RM; g++) begin : g_row
      // write strobe of this row
      assign row_wr[g] = reg_wr && acc_ok && row == ROW_W'(g);

      // next value of this row: hold unless written now
      always_comb begin
        ptr_d[g] = ptr_q[g];
        opt_d[g] = opt_q[g];
        // writes outside shutdown are ignored
        if (row_wr[g]) begin
          if (reg_pick == SEL_POINTER) begin
            // pointer register
            ptr_d[g] = mask_ptr(reg_wdata);
          end else begin
            // load options register, reserved bits dropped
            opt_d[g] = reg_wdata[OPT_USED_W-1:0];
          end
        end
      end

      // row registers only; reset clears every field
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          ptr_q[g] <= POINTER_RESET;
          opt_q[g] <= OPTIONS_RESET;
        end else begin
          ptr_q[g] <= ptr_d[g];
          opt_q[g] <= opt_d[g];
        end
      end
    end
  endgenerate

  // read mux; rows past NUM_RM and any read outside shutdown give zero
  // read data is registered, so it answers the select of the last cycle;
  // a read and a write of one register in the same cycle return the old value
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (acc_ok) begin
      if (reg_pick == SEL_POINTER) begin
        // pointer: load row low, clearing row or zero high
        rdata_d = ptr_q[row];
      end else begin
        // options: used bits only
        rdata_d = opt_word(opt_q[row]);
      end
    end
  end

  // read data register only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // read data leaves straight from the flop
  assign reg_rdata = rdata_q;

  // load side: information of the module named by load_rm_id
  logic                  id_ok;       // load id names an implemented row
  logic [OPT_USED_W-1:0] sel_opt;     // options row of the load id
  logic [31:0]           sel_ptr;     // pointer row of the load id
  logic [OPT_USED_W-1:0] info_opt_q;  // registered options of the load id
  logic [OPT_USED_W-1:0] info_opt_d;  // next options of the load id
  logic [31:0]           info_ptr_q;  // registered pointer of the load id
  logic [31:0]           info_ptr_d;  // next pointer of the load id

  // an id past the implemented rows loads nothing
  assign id_ok = row_exists(load_rm_id);

  // pick the row of the load id; a missing row looks like a reset row,
  // which decodes as no reset, no start-up and no shutdown
  always_comb begin
    sel_opt = OPTIONS_RESET;
    sel_ptr = POINTER_RESET;
    if (id_ok) begin
      sel_opt = opt_q[load_rm_id];
      sel_ptr = ptr_q[load_rm_id];
    end
    info_opt_d = sel_opt;
    info_ptr_d = sel_ptr;
  end

  // decode registers only; outputs lag load_rm_id by one cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      info_ptr_q <= POINTER_RESET;
      info_opt_q <= OPTIONS_RESET;
    end else begin
      info_ptr_q <= info_ptr_d;
      info_opt_q <= info_opt_d;
    end
  end

  // pointer fields; the clearing row reads zero without clearing images,
  // as the upper half was never stored
  assign load_image_row     = info_ptr_q[LOAD_ROW_LSB +: LOAD_ROW_W];
  assign clearing_image_row = info_ptr_q[CLEAR_ROW_LSB +: CLEAR_ROW_W];

  // load option fields
  assign startup_needed     = info_opt_q[STARTUP_POS];
  assign shutdown_mode      = info_opt_q[SHUT_REQ_LSB +: SHUT_REQ_W];
  assign reset_mode         = info_opt_q[RST_REQ_LSB +: RST_REQ_W];

  // reset pulse uses the live row so it starts the cycle after load_start;
  // the registered reset_mode above lags, so a sequencer should set
  // load_rm_id one cycle ahead when it wants both to agree;
  // a start while a pulse runs is dropped inside the pulse generator
  mib_rst_pulse u_pulse (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .start    (load_start && id_ok),
    .duration (sel_opt[RST_DUR_LSB +: RST_DUR_W]),
    .req      (sel_opt[RST_REQ_LSB +: RST_REQ_W]),
    .rm_reset (rm_reset),
    .busy     (rm_reset_busy)
  );

endmodule // mib_bank

// ===== pkg/mib_pkg.sv
// package for the module information register bank: layout, encodings, reset values
package mib_pkg;

  // register select: lsb picks the register within a row
  localparam int SEL_LSB_POS = 0;
  localparam logic SEL_POINTER = 1'h0;
  localparam logic SEL_OPTIONS = 1'h1;

  // bitstream pointer fields
  localparam int LOAD_ROW_LSB  = 0;
  localparam int LOAD_ROW_W    = 16;
  localparam int CLEAR_ROW_LSB = 16;
  localparam int CLEAR_ROW_W   = 16;

  // load options fields
  localparam int OPT_USED_W    = 13;
  localparam int RST_DUR_LSB   = 5;
  localparam int RST_DUR_W     = 8;
  localparam int RST_REQ_LSB   = 3;
  localparam int RST_REQ_W     = 2;
  localparam int STARTUP_POS   = 2;
  localparam int SHUT_REQ_LSB  = 0;
  localparam int SHUT_REQ_W    = 2;

  // reset values
  localparam logic [31:0] POINTER_RESET = 32'h0000_0000;
  localparam logic [12:0] OPTIONS_RESET = 13'h0000;

  // reset requirement codes
  typedef enum logic [1:0] {
    RST_NONE     = 2'h0,
    RST_RESERVED = 2'h1,
    RST_LOW      = 2'h2,
    RST_HIGH     = 2'h3
  } mib_rst_req_type;

  // shutdown requirement codes
  typedef enum logic [1:0] {
    SHUT_NONE     = 2'h0,
    SHUT_HW       = 2'h1,
    SHUT_HW_SW    = 2'h2,
    SHUT_SW_HW    = 2'h3
  } mib_shut_req_type;

endpackage

// ===== src/mib_rst_pulse.sv
// module reset pulse generator for one reconfigurable module load
`timescale 1ns/1ps
module mib_rst_pulse
  import mib_pkg::*;
(
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // request
  input  wire logic                 start,
  input  wire logic [RST_DUR_W-1:0] duration,
  input  wire logic [1:0]           req,
  // output
  output logic                      rm_reset,
  output logic                      busy
);

  logic [RST_DUR_W-1:0] cnt_q, cnt_d;   // cycles left minus one
  logic                 act_q, act_d;   // pulse in progress
  logic                 pol_q, pol_d;   // 1 = active high
  logic                 out_q, out_d;   // registered reset level

  // next-state logic for the pulse counter
  always_comb begin
    cnt_d = cnt_q;
    act_d = act_q;
    pol_d = pol_q;
    if (act_q) begin
      if (cnt_q == '0) begin
        act_d = 1'h0;
      end else begin
        cnt_d = cnt_q - 8'h01;
      end
    end else if (start && (req == RST_LOW || req == RST_HIGH)) begin
      // code 00 and reserved 01 give no pulse, duration ignored
      act_d = 1'h1;
      cnt_d = duration;
      pol_d = (req == RST_HIGH);
    end
    // idle level follows the polarity: deasserted
    out_d = act_d ? pol_d : ~pol_d;
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= '0;
      act_q <= 1'h0;
      pol_q <= 1'h1;
      out_q <= 1'h0;
    end else begin
      cnt_q <= cnt_d;
      act_q <= act_d;
      pol_q <= pol_d;
      out_q <= out_d;
    end
  end

  assign rm_reset = out_q;
  assign busy     = act_q;

endmodule // mib_rst_pulse

// ===== tb/mib_bank_checker.sv
// assertion checker for the module information register bank
`timescale 1ns/1ps
module mib_bank_checker
  import mib_pkg::*;
#(
  parameter int NUM_RM    = 4,
  parameter int ROW_W     = 2,
  parameter bit HAS_CLEAR = 1'h0
) (
  // clock and reset
  input wire logic             ref_clk,
  input wire logic             rst,
  // register side
  input wire logic [ROW_W:0]   reg_sel,
  input wire logic [31:0]      reg_rdata,
  input wire logic             in_shutdown,
  // module reset side
  input wire logic             load_start,
  input wire logic [1:0]       reset_mode,
  input wire logic             rm_reset,
  input wire logic             rm_reset_busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // busy cycles seen so far, caps the pulse length
  logic [8:0] cnt_q, cnt_d;
  always_comb cnt_d = (rst || !rm_reset_busy) ? 9'h000 : cnt_q + 9'h001;
  always_ff @(posedge ref_clk) cnt_q <= cnt_d;
  chk_rd_gate: assert property (!$past(in_shutdown) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside shutdown");
  chk_opt_resv: assert property ($past(reg_sel[0]) |-> reg_rdata[31:13] == 19'h0)
    else $error("options upper bits not zero");
  chk_ptr_resv: assert property (!HAS_CLEAR && !$past(reg_sel[0]) |->
    reg_rdata[31:16] == 16'h0) else $error("pointer upper bits not zero");
  chk_rd_range: assert property ($past(reg_sel[ROW_W:1]) >= NUM_RM |->
    reg_rdata == 32'h0) else $error("missing row read not zero");
  chk_pulse_cause: assert property ($rose(rm_reset_busy) |-> $past(load_start))
    else $error("pulse without load request");
  chk_busy_cap: assert property (rm_reset_busy |-> cnt_q < 9'h100)
    else $error("pulse longer than 256 cycles");
  chk_rst_level: assert property (rm_reset_busy |-> rm_reset == reset_mode[0])
    else $error("pulse polarity wrong");
  chk_no_pulse: assert property (load_start && !rm_reset_busy && !reset_mode[1]
    |=> !rm_reset_busy) else $error("pulse for no-reset code");
endmodule // mib_bank_checker

bind mib_bank mib_bank_checker #(.NUM_RM(NUM_RM), .ROW_W(ROW_W), .HAS_CLEAR(HAS_CLEAR))
  i_chk (.ref_clk, .rst, .reg_sel, .reg_rdata, .in_shutdown, .load_start, .reset_mode,
  .rm_reset, .rm_reset_busy);

// ===== tb/mib_bank_tb.sv
// self-checking bench for the module information register bank
`timescale 1ns/1ps
module mib_bank_tb;
  import mib_pkg::*;
  localparam int NR = 3; // one row short, so row 3 stays unmapped
  logic        ref_clk = 0, rst = 1, reg_wr = 0, in_shutdown = 1, load_start = 0;
  logic [2:0]  reg_sel = 0;
  logic [1:0]  load_rm_id = 0, shutdown_mode, reset_mode;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [15:0] load_image_row, clearing_image_row;
  logic        startup_needed, rm_reset, rm_reset_busy;
  int          n_fail = 0, num_checks = 0;
  logic [31:0] ptr_m [4] = '{default: 0}; // model of the pointer rows
  logic [31:0] opt_m [4] = '{default: 0}; // model of the options rows
  mib_bank #(.NUM_RM(NR)) i_mib_bank (.ref_clk, .rst, .reg_sel, .reg_wr, .reg_wdata,
    .reg_rdata, .in_shutdown, .load_start, .load_rm_id, .load_image_row,
    .clearing_image_row, .startup_needed, .shutdown_mode, .reset_mode, .rm_reset,
    .rm_reset_busy);
  initial forever #5 ref_clk = ~ref_clk;
  // compare and count
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one write, model follows the gating and reserved bits
  task automatic wr(logic [2:0] s, logic [31:0] d);
    reg_sel = s;
    reg_wdata = d;
    reg_wr = 1;
    @(posedge ref_clk);
    #1 reg_wr = 0;
    if (in_shutdown && s[2:1] < NR) begin
      if (s[0]) opt_m[s[2:1]] = d & 32'h0000_1FFF;
      else ptr_m[s[2:1]] = d & 32'h0000_FFFF;
    end
    @(posedge ref_clk);
    #1;
  endtask
  // one read, data lands one edge later
  task automatic rd(logic [2:0] s);
    reg_sel = s;
    @(posedge ref_clk);
    #1;
    chk("rdata", reg_rdata, !(in_shutdown && s[2:1] < NR) ? 32'h0 :
      s[0] ? opt_m[s[2:1]] : ptr_m[s[2:1]]);
  endtask
  // program a row's load options, check decoded outputs, then time the reset pulse
  task automatic pl(logic [1:0] r, logic [7:0] du, logic [1:0] cd);
    logic [31:0] d;
    int n;
    n = 0;
    d = $urandom;
    d[12:3] = {du, cd};
    wr({r, 1'b1}, d);
    load_rm_id = r;
    @(posedge ref_clk);
    #1;
    chk("mode", reset_mode, opt_m[r][4:3]);
    chk("startup", startup_needed, opt_m[r][2]);
    chk("shutdown", shutdown_mode, opt_m[r][1:0]);
    chk("image", load_image_row, ptr_m[r][15:0]);
    chk("clear", clearing_image_row, ptr_m[r][31:16]);
    load_start = 1;
    @(posedge ref_clk);
    #1 load_start = 0;
    if (cd[1]) chk("level", rm_reset, cd[0]);
    while (rm_reset_busy && n < 300) begin
      n++;
      @(posedge ref_clk);
      #1;
    end
    chk("pulse", n, cd[1] ? 32'(du) + 32'h1 : 32'h0);
    if (cd[1]) chk("idle", rm_reset, !cd[0]);
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // hang guard, far beyond the expected run of about 700 cycles
  initial begin
    #300us;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    void'($urandom(36920));
    repeat (16) @(posedge ref_clk);
    #1 rst = 0;
    for (int i = 0; i < 8; i++) rd(3'(i));
    // random writes, a quarter of them outside shutdown
    repeat (60) begin
      in_shutdown = ($urandom % 4) != 0;
      wr(3'($urandom), $urandom);
    end
    for (int k = 0; k < 16; k++) begin
      in_shutdown = k[3];
      rd(3'(k));
    end
    // every reset code at both duration extremes
    for (int c = 0; c < 4; c++) begin
      pl(2'(c % NR), 8'h00, 2'(c));
      pl(2'(c % NR), 8'hFF, 2'(c));
    end
    tally_and_finish();
  end
endmodule // mib_bank_tb
